// [rtl/scoreboard_pkg.sv]
// Package of constants and carrier types for the load register scoreboard.
package scoreboard_pkg;
    localparam int unsigned REG_COUNT  = 32;
    localparam int unsigned REG_IDX_W  = 5;
    localparam int unsigned SLOT_COUNT = 3;
    localparam int unsigned SRC_COUNT  = 3;

    typedef logic [REG_IDX_W-1:0] reg_idx_t;

    // One instruction offered by the issue stage.
    typedef struct packed {
        logic                     is_load;
        logic                     dst_used;
        reg_idx_t                 dst;
        logic [SRC_COUNT-1:0]     src_used;
        reg_idx_t [SRC_COUNT-1:0] src;
    } issue_req_t;

    // Completion of a load once its data sits in the register file.
    typedef struct packed {
        logic     valid;
        reg_idx_t dst;
    } load_done_t;

    typedef enum logic [1:0] {
        SLOT_FREE = 2'b00,
        SLOT_BUSY = 2'b01
    } slot_state_t;
endpackage

// [rtl/busy_lookup.sv]
// Combinational test of one register index against the busy vector.
`timescale 1ns/1ns
module busy_lookup (
    input  wire logic [scoreboard_pkg::REG_COUNT-1:0] busy,
    input  wire scoreboard_pkg::reg_idx_t             idx,
    input  wire logic                                 used,
    output logic                                      hit
);
    assign hit = used & busy[idx];
endmodule

// [rtl/load_register_scoreboard.sv]
// Load register scoreboard: busy bits, load slots and issue hold.
`timescale 1ns/1ns
module load_register_scoreboard (
    input  wire logic                             clk_sys,
    input  wire logic                             rst,
    input  wire logic                             issue_valid,
    input  wire scoreboard_pkg::issue_req_t       issue_req,
    output logic                                  issue_ready,
    input  wire scoreboard_pkg::load_done_t       load_done,
    output logic [scoreboard_pkg::REG_COUNT-1:0]  busy_out,
    output logic [1:0]                            pending_count
);
    // ****************************************************************
    // Slot state and busy vector
    // ****************************************************************
    scoreboard_pkg::slot_state_t                          slot_reg [scoreboard_pkg::SLOT_COUNT];
    scoreboard_pkg::reg_idx_t                             slot_dst_reg [scoreboard_pkg::SLOT_COUNT];
    logic [scoreboard_pkg::REG_COUNT-1:0]                 busy;
    logic [scoreboard_pkg::SLOT_COUNT-1:0]                slot_free;
    logic [scoreboard_pkg::SLOT_COUNT-1:0]                slot_done;
    logic [scoreboard_pkg::SLOT_COUNT-1:0]                slot_pick;
    logic [scoreboard_pkg::SRC_COUNT-1:0]                 src_hit;
    logic                                                 dst_hit;
    logic                                                 any_free;
    logic                                                 load_fire;
    logic [1:0]                                           pending_next;

    // Only one slot ever holds a given register, so busy bits map one to one.
    always_comb begin
        busy = '0;
        for (int s = 0; s < scoreboard_pkg::SLOT_COUNT; s++) begin
            if (slot_reg[s] == scoreboard_pkg::SLOT_BUSY) begin
                busy[slot_dst_reg[s]] = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Issue check
    // ****************************************************************
    // Sources are checked against busy bits; any instruction also waits when its
    // destination is still pending so a slot never doubles a register.
    genvar g;
    generate
        for (g = 0; g < scoreboard_pkg::SRC_COUNT; g++) begin : gen_src
            busy_lookup u_src (
                .busy (busy),
                .idx  (issue_req.src[g]),
                .used (issue_req.src_used[g]),
                .hit  (src_hit[g])
            );
        end
    endgenerate

    busy_lookup u_dst (
        .busy (busy),
        .idx  (issue_req.dst),
        .used (issue_req.dst_used),
        .hit  (dst_hit)
    );

    // ****************************************************************
    // Slot selection
    // ****************************************************************
    // The lowest free slot wins, so the choice is stable from cycle to cycle.
    always_comb begin
        slot_pick = '0;
        for (int s = scoreboard_pkg::SLOT_COUNT - 1; s >= 0; s--) begin
            slot_free[s] = (slot_reg[s] == scoreboard_pkg::SLOT_FREE);
            slot_done[s] = load_done.valid && !slot_free[s] && (slot_dst_reg[s] == load_done.dst);
        end
        for (int s = scoreboard_pkg::SLOT_COUNT - 1; s >= 0; s--) begin
            if (slot_free[s]) begin
                slot_pick = '0;
                slot_pick[s] = 1'b1;
            end
        end
    end

    assign any_free    = |slot_free;
    // Busy sources or a busy destination hold issue; loads need a free slot; nothing else stalls.
    assign issue_ready = ~|src_hit && !dst_hit
                         && (!issue_req.is_load || any_free);
    assign load_fire   = issue_valid && issue_ready && issue_req.is_load;

    // ****************************************************************
    // Slot update
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int s = 0; s < scoreboard_pkg::SLOT_COUNT; s++) begin
                slot_reg[s]     <= scoreboard_pkg::SLOT_FREE;
                slot_dst_reg[s] <= '0;
            end
        end else begin
            for (int s = 0; s < scoreboard_pkg::SLOT_COUNT; s++) begin
                if (load_fire && slot_pick[s]) begin
                    slot_reg[s]     <= scoreboard_pkg::SLOT_BUSY;
                    slot_dst_reg[s] <= issue_req.dst;
                end else if (slot_done[s]) begin
                    slot_reg[s] <= scoreboard_pkg::SLOT_FREE;
                end
            end
        end
    end

    // ****************************************************************
    // Outstanding load count
    // ****************************************************************
    // At most three slots exist, so two bits always hold the count.
    always_comb begin
        pending_next = 2'h0;
        for (int s = 0; s < scoreboard_pkg::SLOT_COUNT; s++) begin
            if (!slot_free[s]) begin
                pending_next = pending_next + 2'h1;
            end
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_out      <= '0;
            pending_count <= 2'h0;
        end else begin
            busy_out      <= busy;
            pending_count <= pending_next;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_load_sets_busy: assert property (@(posedge clk_sys) disable iff (rst)
        load_fire |=> busy[$past(issue_req.dst)])
        else $error("Issued load did not mark its destination busy.");

    a_done_clears_busy: assert property (@(posedge clk_sys) disable iff (rst)
        (load_done.valid && busy[load_done.dst] && !load_fire) |=> !busy[$past(load_done.dst)])
        else $error("Completed load left its register busy.");

    a_nonload_no_mark: assert property (@(posedge clk_sys) disable iff (rst)
        !load_fire |=> ($countones(busy) <= $countones($past(busy))))
        else $error("Busy count rose without a load issue.");

    a_busy_src_holds: assert property (@(posedge clk_sys) disable iff (rst)
        (issue_req.src_used[0] && busy[issue_req.src[0]]) |-> !issue_ready)
        else $error("Instruction issued with a busy source.");

    a_nonload_free: assert property (@(posedge clk_sys) disable iff (rst)
        (!issue_req.is_load && !(|src_hit) && !dst_hit) |-> issue_ready)
        else $error("Unrelated instruction stalled.");

    a_max_three: assert property (@(posedge clk_sys) disable iff (rst)
        $countones(busy) <= 3)
        else $error("More than three loads outstanding.");

    a_full_stalls: assert property (@(posedge clk_sys) disable iff (rst)
        (!any_free && issue_req.is_load) |-> !issue_ready)
        else $error("Load issued with all slots taken.");

    a_check_sources: assert property (@(posedge clk_sys) disable iff (rst)
        (issue_valid && issue_ready) |-> !(issue_req.src_used[2] && busy[issue_req.src[2]]))
        else $error("Third source not checked at issue.");

    a_src0_checked: assert property (@(posedge clk_sys) disable iff (rst)
        (issue_valid && issue_ready) |-> !(issue_req.src_used[0] && busy[issue_req.src[0]]))
        else $error("First source not checked at issue.");

    a_src1_checked: assert property (@(posedge clk_sys) disable iff (rst)
        (issue_valid && issue_ready) |-> !(issue_req.src_used[1] && busy[issue_req.src[1]]))
        else $error("Second source not checked at issue.");

    a_src1_holds: assert property (@(posedge clk_sys) disable iff (rst)
        (issue_req.src_used[1] && busy[issue_req.src[1]]) |-> !issue_ready)
        else $error("Instruction issued with a busy second source.");

    a_src2_holds: assert property (@(posedge clk_sys) disable iff (rst)
        (issue_req.src_used[2] && busy[issue_req.src[2]]) |-> !issue_ready)
        else $error("Instruction issued with a busy third source.");

    a_dst_holds: assert property (@(posedge clk_sys) disable iff (rst)
        (issue_req.dst_used && busy[issue_req.dst]) |-> !issue_ready)
        else $error("Instruction issued with a busy destination.");

    a_ready_idle: assert property (@(posedge clk_sys) disable iff (rst)
        (!issue_req.is_load && !(|issue_req.src_used) && !issue_req.dst_used) |-> issue_ready)
        else $error("Instruction without registers was stalled.");

    a_nonload_no_slot: assert property (@(posedge clk_sys) disable iff (rst)
        (issue_valid && issue_ready && !issue_req.is_load && !load_done.valid)
        |=> (busy == $past(busy)))
        else $error("Non-load issue changed the busy bits.");

    a_done_ignored: assert property (@(posedge clk_sys) disable iff (rst)
        (load_done.valid && !busy[load_done.dst] && !load_fire) |=> (busy == $past(busy)))
        else $error("Unmatched completion changed the busy bits.");

    a_pick_onehot: assert property (@(posedge clk_sys) disable iff (rst)
        $onehot0(slot_pick))
        else $error("More than one slot picked for a load.");

    a_pick_free: assert property (@(posedge clk_sys) disable iff (rst)
        any_free |-> (|(slot_pick & slot_free)))
        else $error("Free slot present but none picked.");

    a_busy_per_slot: assert property (@(posedge clk_sys) disable iff (rst)
        $countones(busy) == int'(pending_next))
        else $error("Busy bits do not match the taken slots.");

    a_busy_out_copy: assert property (@(posedge clk_sys) disable iff (rst)
        1'b1 |=> (busy_out == $past(busy)))
        else $error("Busy output does not follow the busy bits.");

    a_count_tracks: assert property (@(posedge clk_sys) disable iff (rst)
        1'b1 |=> (pending_count == $past(pending_next)))
        else $error("Pending count does not follow the taken slots.");
endmodule

// [sim/load_unit_model.sv]
// Load unit model that returns one load after a chosen delay.
`timescale 1ns/1ns
module load_unit_model (
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire logic                     go,
    input  wire scoreboard_pkg::reg_idx_t go_dst,
    input  wire logic [3:0]               lat,
    output scoreboard_pkg::load_done_t    done
);
    logic [3:0]               cnt_reg;
    scoreboard_pkg::reg_idx_t dst_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_reg <= 4'h0;
            dst_reg <= '0;
        end else if (go) begin
            cnt_reg <= lat;
            dst_reg <= go_dst;
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end
    // Between pulses the index is inverted so a stale index cannot match.
    assign done.valid = (cnt_reg == 4'h1);
    assign done.dst   = done.valid ? dst_reg : ~dst_reg;
endmodule

// [sim/testbench.sv]
// Self-checking testbench for the load register scoreboard.
`timescale 1ns/1ns
module testbench;
    logic                       clk_sys, rst, issue_valid, issue_ready, go;
    scoreboard_pkg::issue_req_t req;
    scoreboard_pkg::load_done_t done;
    scoreboard_pkg::reg_idx_t   go_dst;
    logic [31:0]                busy_out;
    logic [1:0]                 pend;
    logic [3:0]                 lat;
    int                         err_count, n_checks;
    load_register_scoreboard u_dut (.clk_sys(clk_sys), .rst(rst), .issue_valid(issue_valid),
        .issue_req(req), .issue_ready(issue_ready), .load_done(done), .busy_out(busy_out),
        .pending_count(pend));
    load_unit_model u_lu (.clk_sys(clk_sys), .rst(rst), .go(go), .go_dst(go_dst), .lat(lat),
        .done(done));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic offer(input logic ld, input logic [4:0] d, input logic [4:0] s, input logic r);
        issue_valid = 1'b1;
        req = '{is_load: ld, dst_used: 1'b1, dst: d, src_used: 3'h1, src: {10'h0, s}};
        #9;
        chk({31'h0, issue_ready}, {31'h0, r});
        @(posedge clk_sys);
        #1;
    endtask
    task automatic sc_third_src();
        req = '{is_load: 1'b0, dst_used: 1'b0, dst: 5'h0, src_used: 3'h4, src: {5'h05, 10'h0}};
        #9;
        chk({31'h0, issue_ready}, 32'h0);
        @(posedge clk_sys);
        #1;
    endtask
    task automatic ret(input logic [4:0] d, input logic [3:0] l);
        int i;
        issue_valid = 1'b0;
        go = 1'b1;
        go_dst = d;
        lat = l;
        @(posedge clk_sys);
        #1;
        go = 1'b0;
        for (i = 0; i < 20 && done.valid !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (i == 20) begin
            err_count++;
            wrap_up();
        end
        @(posedge clk_sys);
        #1;
    endtask
    task automatic sc_nonstall();
        offer(1'b1, 5'h04, 5'h01, 1'b1);
        offer(1'b1, 5'h05, 5'h02, 1'b1);
        offer(1'b0, 5'h07, 5'h01, 1'b1);
        offer(1'b0, 5'h06, 5'h04, 1'b0);
        chk(busy_out, 32'h0000_0030);
        chk({30'h0, pend}, 32'h2);
        offer(1'b0, 5'h06, 5'h05, 1'b0);
    endtask
    task automatic sc_full();
        offer(1'b1, 5'h14, 5'h01, 1'b1);
        offer(1'b1, 5'h1F, 5'h01, 1'b0);
        chk(busy_out, 32'h0010_0030);
        chk({30'h0, pend}, 32'h3);
    endtask
    task automatic sc_return();
        ret(5'h04, 4'h1);
        offer(1'b0, 5'h06, 5'h04, 1'b1);
        offer(1'b1, 5'h1F, 5'h01, 1'b1);
        ret(5'h05, 4'h5);
        ret(5'h14, 4'h2);
        ret(5'h1F, 4'h3);
        @(posedge clk_sys);
        #1;
        chk(busy_out, 32'h0);
        chk({30'h0, pend}, 32'h0);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        {err_count, n_checks} = '0;
        {rst, issue_valid, go, lat, go_dst} = {3'h4, 4'h1, 5'h0};
        req = '0;
        repeat (20) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        sc_nonstall();
        sc_third_src();
        sc_full();
        sc_return();
        wrap_up();
    end
endmodule
